// ### shared/ext_mem_pkg.sv
// package: register map, field layout and enumerations of the external memory bus timing block
package ext_mem_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] TIMING_ADDR  = 8'h84;  // ext_bus_timing_control, every page
  localparam logic [7:0] TIMING_RESET = 8'hff;  // slowest timing after reset

  // ****************************************
  // timing register fields
  // ****************************************
  localparam int SETUP_HI  = 7;  // addr_setup_cycles msb
  localparam int SETUP_LO  = 6;  // addr_setup_cycles lsb
  localparam int STROBE_HI = 5;  // strobe_width_code msb
  localparam int STROBE_LO = 2;  // strobe_width_code lsb
  localparam int HOLD_HI   = 1;  // addr_hold_cycles msb
  localparam int HOLD_LO   = 0;  // addr_hold_cycles lsb

  // ****************************************
  // configuration codes (mux_select_bit and memory mode)
  // ****************************************
  localparam logic [2:0] CFG_MUX_NOBANK_A   = 3'h1;  // multiplexed, no bank select
  localparam logic [2:0] CFG_MUX_BANK       = 3'h2;  // multiplexed, bank select
  localparam logic [2:0] CFG_MUX_NOBANK_B   = 3'h3;  // multiplexed, no bank select
  localparam logic [2:0] CFG_NONMUX_NOBANK_A = 3'h5; // non-multiplexed, no bank select
  localparam logic [2:0] CFG_NONMUX_BANK    = 3'h6;  // non-multiplexed, bank select
  localparam logic [2:0] CFG_NONMUX_NOBANK_B = 3'h7; // non-multiplexed, no bank select
  localparam int         CFG_MUX_BIT        = 2;     // mux_select_bit position, 0 = multiplexed

  // fixed overhead cycles per off-chip move
  localparam logic [3:0] FIXED_OVERHEAD = 4'h4;

  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH_HI, ST_LATCH_LO, ST_SETUP, ST_STROBE, ST_HOLD, ST_TAIL
  } seq_state_t;

  // one external move request from the core
  typedef struct packed {
    logic        isWrite;   // 1 = write, 0 = read
    logic        wide;      // 1 = 16-bit pointer move, 0 = 8-bit pointer move
    logic [15:0] widePtr;   // wide_data_pointer
    logic [7:0]  lowPtr;    // indirect_pointer_zero or _one, as chosen by the core
    logic [7:0]  pageByte;  // upper_page_byte
    logic [7:0]  wrData;    // write data
  } move_req_t;

  // pins facing the external memory
  typedef struct packed {
    logic [7:0] addrHi;     // upper address lines
    logic       addrHiOe;   // upper address lines driven
    logic [7:0] addrLo;     // lower address lines (non-multiplexed)
    logic       addrLoOe;   // lower address lines driven
    logic [7:0] dataOut;    // data / multiplexed address-data out
    logic       dataOe;     // data lines driven
    logic       latchEn;    // address latch strobe, high = transparent
    logic       rdStrobeN;  // read strobe, active low
    logic       wrStrobeN;  // write strobe, active low
  } mem_pins_t;

endpackage

// ### logic/ext_mem_bus_timing.sv
// external data memory bus timing sequencer
`timescale 1ns/1ps
`default_nettype none

module ext_mem_bus_timing
  import ext_mem_pkg::*;
(
  input  wire logic      core_clk,     // system clock
  input  wire logic      rst,          // async reset, active high
  input  wire logic [7:0] sfrAddr,     // register address from the core
  input  wire logic      sfrWrite,     // register write strobe
  input  wire logic [7:0] sfrWdata,    // register write data
  output logic     [7:0] sfrRdata,     // register read data
  input  wire logic [2:0] extBusConfig, // ext_bus_config mode/mux value
  input  wire logic [1:0] latchPulseWidthCode, // latch_pulse_width_code
  input  wire logic      moveStart,    // external_move_instr start pulse
  input  wire move_req_t moveReq,      // move request fields
  output logic           moveBusy,     // sequencer active
  output logic           moveDone,     // one-cycle pulse when move ends
  input  wire logic [7:0] rdDataIn,    // data lines in
  output logic     [7:0] rdData,       // captured read data
  output mem_pins_t      memPins       // external memory pins
);

  // ****************************************
  // timing register
  // ****************************************
  logic [7:0] timingReg;              // ext_bus_timing_control
  seq_state_t stateReg;               // sequencer state
  logic [3:0] cntReg;                 // phase cycle counter
  move_req_t  reqReg;                 // latched request
  logic [2:0] cfgReg;                 // configuration latched at start
  logic [1:0] aleReg;                 // latch width latched at start
  logic [7:0] timReg;                 // timing latched at start

  // register write, reachable regardless of page
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timingReg <= TIMING_RESET;
    end else if (sfrWrite && sfrAddr == TIMING_ADDR) begin
      timingReg <= sfrWdata;
    end
  end

  // register read, unmapped addresses read zero
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sfrRdata <= 8'h00;
    end else begin
      sfrRdata <= (sfrAddr == TIMING_ADDR) ? timingReg : 8'h00;
    end
  end

  // ****************************************
  // decode helpers
  // ****************************************
  // multiplexed when mux_select_bit is clear
  function automatic logic isMuxed(input logic [2:0] cfg);
    return !cfg[CFG_MUX_BIT];
  endfunction

  // bank select drives upper lines from page byte on 8-bit moves
  function automatic logic hasBank(input logic [2:0] cfg);
    return (cfg == CFG_MUX_BANK) || (cfg == CFG_NONMUX_BANK);
  endfunction

  logic       muxed;                  // current move multiplexed
  logic [15:0] effAddr;               // effective address
  logic       upperDriven;            // upper address lines driven
  logic       cfgValid;               // start accepted for off-chip config
  assign muxed    = isMuxed(cfgReg);
  assign cfgValid = (extBusConfig == CFG_MUX_NOBANK_A) || (extBusConfig == CFG_MUX_BANK)
                 || (extBusConfig == CFG_MUX_NOBANK_B) || (extBusConfig == CFG_NONMUX_NOBANK_A)
                 || (extBusConfig == CFG_NONMUX_BANK) || (extBusConfig == CFG_NONMUX_NOBANK_B);

  // address source per move width and bank mode
  always_comb begin
    if (reqReg.wide) begin
      effAddr     = reqReg.widePtr;
      upperDriven = 1'b1;
    end else if (hasBank(cfgReg)) begin
      effAddr     = {reqReg.pageByte, reqReg.lowPtr};
      upperDriven = 1'b1;
    end else begin
      effAddr     = {8'h00, reqReg.lowPtr};
      upperDriven = 1'b0;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  // latch phases, setup, strobe, hold, fixed tail; total = 5 + setup + strobe + hold codes, plus 2*(latch code + 1) when multiplexed
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg <= ST_IDLE;
      cntReg   <= 4'h0;
      reqReg   <= '0;
      cfgReg   <= 3'h0;
      aleReg   <= 2'h0;
      timReg   <= TIMING_RESET;
    end else begin
      case (stateReg)
        ST_IDLE: begin
          if (moveStart && cfgValid) begin
            reqReg <= moveReq;
            cfgReg <= extBusConfig;
            aleReg <= latchPulseWidthCode;
            timReg <= timingReg;
            cntReg <= 4'h0;
            stateReg <= isMuxed(extBusConfig) ? ST_LATCH_HI : ST_SETUP;
          end
        end
        ST_LATCH_HI: begin            // latch strobe high phase
          if (cntReg == {2'b00, aleReg}) begin
            cntReg   <= 4'h0;
            stateReg <= ST_LATCH_LO;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
        ST_LATCH_LO: begin            // latch strobe low phase
          if (cntReg == {2'b00, aleReg}) begin
            cntReg   <= 4'h0;
            stateReg <= ST_SETUP;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
        ST_SETUP: begin               // setup: one to four cycles
          if (cntReg == {2'b00, timReg[SETUP_HI:SETUP_LO]}) begin
            cntReg   <= 4'h0;
            stateReg <= ST_STROBE;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
        ST_STROBE: begin              // strobe: code plus one cycles
          if (cntReg == timReg[STROBE_HI:STROBE_LO]) begin
            cntReg   <= 4'h0;
            stateReg <= ST_HOLD;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
        ST_HOLD: begin                // hold: one to four cycles
          if (cntReg == {2'b00, timReg[HOLD_HI:HOLD_LO]}) begin
            cntReg   <= 4'h0;
            stateReg <= ST_TAIL;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
        ST_TAIL: begin                // remaining fixed overhead cycles, same length in both bus modes
          if (cntReg == FIXED_OVERHEAD - 4'h3) begin
            cntReg   <= 4'h0;
            stateReg <= ST_IDLE;
          end else begin
            cntReg <= cntReg + 4'h1;
          end
        end
        default: begin
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  logic inStrobe;                     // strobe phase active
  logic inCycle;                      // address/data phases of a move
  assign inStrobe = (stateReg == ST_STROBE);
  assign inCycle  = (stateReg == ST_SETUP) || inStrobe || (stateReg == ST_HOLD);

  // registered pins; address and data stable from setup through hold
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      memPins <= '{addrHi: 8'h00, addrHiOe: 1'b0, addrLo: 8'h00, addrLoOe: 1'b0,
                   dataOut: 8'h00, dataOe: 1'b0, latchEn: 1'b0,
                   rdStrobeN: 1'b1, wrStrobeN: 1'b1};
    end else begin
      memPins.addrHi    <= effAddr[15:8];
      memPins.addrHiOe  <= (stateReg != ST_IDLE) && (stateReg != ST_TAIL) && upperDriven;
      memPins.addrLo    <= effAddr[7:0];
      memPins.addrLoOe  <= inCycle && !muxed;
      memPins.latchEn   <= (stateReg == ST_LATCH_HI);
      // muxed: low address during latch, then data; non-muxed: data only on writes
      if (stateReg == ST_LATCH_HI || stateReg == ST_LATCH_LO) begin
        memPins.dataOut <= effAddr[7:0];
        memPins.dataOe  <= 1'b1;
      end else begin
        memPins.dataOut <= reqReg.wrData;
        memPins.dataOe  <= inCycle && reqReg.isWrite;
      end
      memPins.rdStrobeN <= !(inStrobe && !reqReg.isWrite);
      memPins.wrStrobeN <= !(inStrobe && reqReg.isWrite);
    end
  end

  // read data sampled on the last strobe cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData <= 8'h00;
    end else if (stateReg == ST_HOLD && cntReg == 4'h0 && !reqReg.isWrite) begin
      rdData <= rdDataIn;
    end
  end

  // status toward the core
  assign moveBusy = (stateReg != ST_IDLE);
  assign moveDone = (stateReg == ST_TAIL)
                 && (cntReg == FIXED_OVERHEAD - 4'h3);

endmodule

`default_nettype wire

// ### bench/ext_mem_bus_timing_props.sv
// checker for the bus timing sequencer ports
`timescale 1ns/1ps
`default_nettype none
module ext_mem_bus_timing_props
  import ext_mem_pkg::*;
(
  input wire logic       core_clk,            // clock
  input wire logic       rst,                 // reset
  input wire logic [7:0] sfrAddr,             // register address
  input wire logic       sfrWrite,            // register write
  input wire logic [7:0] sfrWdata,            // write data
  input wire logic [7:0] sfrRdata,            // read data
  input wire logic [2:0] extBusConfig,        // mode code
  input wire logic [1:0] latchPulseWidthCode, // latch width
  input wire logic       moveStart,           // move start
  input wire move_req_t  moveReq,             // move fields
  input wire logic       moveBusy,            // busy
  input wire logic       moveDone,            // done pulse
  input wire mem_pins_t  memPins              // pins
);
  // ****************************************
  // helper state
  // ****************************************
  logic [7:0] tcShadow, tcRun, expRd;  // timing copies
  logic [1:0] aleRun;                  // latch code of move
  logic       muxRun, hiRun;           // mode of move
  logic [5:0] busyCnt, lowCnt, latCnt; // run lengths
  wire        strobeLow = !(memPins.rdStrobeN && memPins.wrStrobeN);
  wire        accept = moveStart && !moveBusy && extBusConfig[1:0] != 2'h0;
  wire  [5:0] expLen = 6'h5 + tcRun[7:6] + tcRun[5:2] + tcRun[1:0] + (muxRun ? 6'h2 + {3'h0, aleRun, 1'b0} : 6'h0);
  // timing register copy and read expectation
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tcShadow <= TIMING_RESET;
      expRd    <= 8'h00;
    end else begin
      if (sfrWrite && sfrAddr == TIMING_ADDR) tcShadow <= sfrWdata;
      expRd <= (sfrAddr == TIMING_ADDR) ? tcShadow : 8'h00;
    end
  end
  // settings of the accepted move
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tcRun  <= TIMING_RESET;
      aleRun <= 2'h0;
      muxRun <= 1'b0;
      hiRun  <= 1'b0;
    end else if (accept) begin
      tcRun  <= tcShadow;
      aleRun <= latchPulseWidthCode;
      muxRun <= !extBusConfig[CFG_MUX_BIT];
      hiRun  <= moveReq.wide || extBusConfig == CFG_MUX_BANK || extBusConfig == CFG_NONMUX_BANK;
    end
  end
  // run-length counters
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busyCnt <= 6'h0;
      lowCnt  <= 6'h0;
      latCnt  <= 6'h0;
    end else begin
      busyCnt <= moveBusy ? busyCnt + 6'h1 : 6'h0;
      lowCnt  <= strobeLow ? lowCnt + 6'h1 : 6'h0;
      latCnt  <= memPins.latchEn ? latCnt + 6'h1 : 6'h0;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence moveEnd;
    (busyCnt + 6'h1 == expLen) ##1 !moveBusy;
  endsequence
  reg_read_a: assert property (!$past(sfrWrite) |-> sfrRdata == expRd)
    else $error("timing register read wrong");
  strobe_width_a: assert property ($fell(strobeLow) |-> lowCnt == {2'h0, tcRun[5:2]} + 6'h1)
    else $error("strobe width wrong");
  latch_width_a: assert property ($fell(memPins.latchEn) |-> latCnt == {4'h0, aleRun} + 6'h1)
    else $error("latch high time wrong");
  move_length_a: assert property (moveDone |-> moveEnd)
    else $error("move length wrong");
  idle_quiet_a: assert property (!moveBusy && !$past(moveBusy) |-> !strobeLow && !memPins.latchEn)
    else $error("strobe outside a move");
  wdata_stable_a: assert property (!memPins.wrStrobeN && !$past(memPins.wrStrobeN)
    |-> $stable(memPins.dataOut))
    else $error("write data moved in strobe");
  wdata_setup_a: assert property ($fell(memPins.wrStrobeN) |-> $past(memPins.dataOe) && memPins.dataOe)
    else $error("write data not set up");
  upper_drive_a: assert property (strobeLow |-> memPins.addrHiOe == hiRun)
    else $error("upper address drive wrong");
  // write data still driven and unchanged in the first cycle after the strobe
  wdata_hold_a: assert property ($rose(memPins.wrStrobeN) |-> memPins.dataOe && $stable(memPins.dataOut))
    else $error("write data not held");
endmodule
bind ext_mem_bus_timing ext_mem_bus_timing_props ext_mem_bus_timing_props_inst (.core_clk, .rst, .sfrAddr,
  .sfrWrite, .sfrWdata, .sfrRdata, .extBusConfig, .latchPulseWidthCode, .moveStart, .moveReq, .moveBusy,
  .moveDone, .memPins);
`default_nettype wire

// ### bench/ext_mem_model.sv
// asynchronous memory with address latch facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model
  import ext_mem_pkg::*;
(
  input  wire logic       core_clk, // clock
  input  wire mem_pins_t  memPins,  // sequencer pins
  output logic      [7:0] rdDataIn, // data back
  output logic     [15:0] lastAddr, // address at last strobe
  output logic            lastHiOe  // upper lines driven then
);
  logic [7:0] mem [0:65535];  // storage
  logic [7:0] latched;        // latch contents
  logic [7:0] lastVal = 8'h00; // last value driven
  wire [15:0] addr = {memPins.addrHiOe ? memPins.addrHi : 8'h00, memPins.addrLoOe ? memPins.addrLo : latched};
  // released lines show the inverse of the last value
  assign rdDataIn = memPins.rdStrobeN ? ~lastVal : mem[addr];
  // latch follows shared lines while its strobe is high
  always @(posedge core_clk) if (memPins.latchEn) latched <= memPins.dataOut;
  // store, remember and log during strobes
  always @(posedge core_clk) begin
    if (!memPins.rdStrobeN) lastVal <= mem[addr];
    if (!memPins.wrStrobeN) mem[addr] <= memPins.dataOut;
    if (!(memPins.rdStrobeN && memPins.wrStrobeN)) lastAddr <= addr;
    if (!(memPins.rdStrobeN && memPins.wrStrobeN)) lastHiOe <= memPins.addrHiOe;
  end
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the bus timing sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin fails++; \
  $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb
  import ext_mem_pkg::*;
;
  logic        core_clk, rst, sfrWrite, moveStart, moveBusy, moveDone, lastHiOe, mux, bank, ok;
  logic  [7:0] sfrAddr, sfrWdata, sfrRdata, rdDataIn, rdData, d, tc;
  logic  [2:0] extBusConfig;
  logic  [1:0] latchPulseWidthCode, ale;
  logic [15:0] lastAddr, ea;
  move_req_t   moveReq, r;
  mem_pins_t   memPins;
  int          fails, nChecks, cyc, n, expLen;
  logic  [7:0] tcTab [8] = '{8'h00, 8'h00, 8'hff, 8'h5a, 8'h00, 8'h66, 8'hff, 8'h93};
  ext_mem_bus_timing ext_mem_bus_timing_inst (.core_clk, .rst, .sfrAddr, .sfrWrite, .sfrWdata, .sfrRdata,
    .extBusConfig, .latchPulseWidthCode, .moveStart, .moveReq, .moveBusy, .moveDone, .rdDataIn, .rdData, .memPins);
  ext_mem_model ext_mem_model_inst (.core_clk, .memPins, .rdDataIn, .lastAddr, .lastHiOe);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      complete_run;
    end
  end
  task automatic complete_run;
    if (fails == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic regWr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfrAddr  <= a;
    sfrWdata <= v;
    sfrWrite <= 1'b1;
    @(posedge core_clk);
    sfrWrite <= 1'b0;
  endtask
  task automatic regRd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    sfrAddr <= a;
    @(posedge core_clk);
    #1 v = sfrRdata;
  endtask
  // one move; counts busy cycles, zero if refused
  task automatic doMove(input logic [2:0] c, input logic [1:0] w, input move_req_t q, output int len);
    @(posedge core_clk);
    extBusConfig        <= c;
    latchPulseWidthCode <= w;
    moveReq             <= q;
    moveStart           <= 1'b1;
    @(posedge core_clk);
    moveStart <= 1'b0;
    len = 0;
    repeat (100) begin
      @(negedge core_clk);
      if (moveBusy === 1'b1) len++;
      else if (len > 0) break;
    end
  endtask
  initial begin
    rst = 1'b1;
    sfrAddr = 8'h00;
    sfrWdata = 8'h00;
    sfrWrite = 1'b0;
    moveStart = 1'b0;
    moveReq = '0;
    extBusConfig = 3'h0;
    latchPulseWidthCode = 2'h0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    regRd(TIMING_ADDR, d);
    `CHK(d, TIMING_RESET)
    regRd(8'h85, d);
    `CHK(d, 8'h00)
    for (int i = 0; i < 8; i++) begin
      tc = tcTab[i];
      regWr(TIMING_ADDR, tc);
      regRd(TIMING_ADDR, d);
      `CHK(d, tc)
      for (int w = 0; w < 2; w++) begin
        ale = 2'(i + 2 * w);
        r = '{1'b1, w[0], 16'hc3a5 ^ 16'(i), 8'h5a ^ 8'(i), 8'h81 + 8'(i), 8'h3c + 8'(2 * i + w)};
        mux = !i[CFG_MUX_BIT];
        bank = (3'(i) == CFG_MUX_BANK) || (3'(i) == CFG_NONMUX_BANK);
        ok = i[1:0] != 2'h0;
        expLen = ok ? 5 + tc[7:6] + tc[5:2] + tc[1:0] + (mux ? 2 * (ale + 1) : 0) : 0;
        doMove(3'(i), ale, r, n);
        `CHK(n, expLen)
        if (ok) begin
          ea = w ? r.widePtr : {bank ? r.pageByte : 8'h00, r.lowPtr};
          `CHK(lastAddr, ea)
          `CHK(lastHiOe, w[0] | bank)
          r.isWrite = 1'b0;
          doMove(3'(i), ale, r, n);
          `CHK(n, expLen)
          `CHK(rdData, r.wrData)
        end
      end
    end
    // reset again in mid-run: timing register back to slowest
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    regRd(TIMING_ADDR, d);
    `CHK(d, TIMING_RESET)
    complete_run;
  end
endmodule
`default_nettype wire
